// file: src/fei_pkg.sv
package fei_pkg;

    localparam logic [7:0] ADDR_MASK  = 8'h40;
    localparam logic [7:0] ADDR_LATCH = 8'h41;
    localparam logic [7:0] ADDR_LIVE  = 8'h42;

    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] LIVE_RESET  = 8'h20;

    localparam int BIT_OVP   = 0;
    localparam int BIT_THP   = 1;
    localparam int BIT_OPEN  = 2;
    localparam int BIT_SHORT = 3;
    localparam int BIT_STEP  = 4;
    localparam int BIT_DONE  = 5;
    localparam int BIT_ROW   = 6;
    localparam int BIT_BOOST = 7;

    // Sources that raise an event on both edges of their condition.
    localparam logic [7:0] BOTH_EDGE = 8'h82;
    // Bits that exist in the live condition register.
    localparam logic [7:0] LIVE_BITS = 8'hAF;

    typedef struct packed {
        logic boost_ready;
        logic row_fault;
        logic scroll_done;
        logic scroll_step;
        logic rset_low;
        logic rset_open;
        logic thermal_trip;
        logic overvoltage_trip;
    } fei_cond_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fei_acc_t;

endpackage : fei_pkg

// file: src/fei_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fei_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } fei_sync_st_t;

    fei_sync_st_t st_r;
    fei_sync_st_t st_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("fei_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;

endmodule : fei_sync

`default_nettype wire

// file: src/fei_unit.sv
// Behaviour
// - Mask register gates each source; resets zero.
// - Source event sets sticky latch bit.
// - Latch clears only by host read.
// - Status follows conditions; read leaves it.
// - Boost-ready follows hysteretic comparator level.
// - Boost and thermal events on both edges.
// - Thermal status follows hysteretic overtemperature level.
// - Overtemperature clears driver-on and boost-on.
// - No self restart; host rewrites enables.
// - Overvoltage sets status, clears boost-on.
// - Resistor checked when driver-on written one.
// - Resistor low flagged; outputs keep running.
// - Scroll step latches; no status bit.
// - Scroll done sets bit, may interrupt.
// - Row short clears driver-on, latches fault.
`timescale 1ns/1ps
`default_nettype none

module fei_unit (
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire fei_pkg::fei_acc_t i_acc,
    input  wire logic             i_boost_ok_cmp,
    input  wire logic             i_row_short,
    input  wire logic             i_rset_open_cmp,
    input  wire logic             i_rset_low_cmp,
    input  wire logic             i_overtemp_cmp,
    input  wire logic             i_overvolt_cmp,
    input  wire logic             i_scroll_step,
    input  wire logic             i_scroll_end,
    input  wire logic             i_scroll_busy,
    input  wire logic             i_driver_on_wr,
    input  wire logic             i_driver_on_wdata,
    input  wire logic             i_boost_on_wr,
    input  wire logic             i_boost_on_wdata,
    output logic      [7:0]       o_rdata,
    output logic                  o_driver_on,
    output logic                  o_boost_on,
    output logic                  o_rset_check,
    output logic                  o_irq
);

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] latch;
        logic [7:0] live;
        logic [7:0] live_d;
        logic [7:0] rdata;
        logic       driver_on;
        logic       boost_on;
        logic       check;
        logic       open_flag;
        logic       low_flag;
    } fei_st_t;

    fei_st_t st_r;
    fei_st_t st_nxt;

    logic [5:0] cmp_sync;

    // Single-bit masks used by the consistency checks and the event assertions.
    localparam logic [7:0] DONE_ONE  = 8'(1 << fei_pkg::BIT_DONE);
    localparam logic [7:0] BOOST_ONE = 8'(1 << fei_pkg::BIT_BOOST);
    localparam logic [7:0] THP_ONE   = 8'(1 << fei_pkg::BIT_THP);
    // Scroll done latches on the end pulse, not on the busy level, so it is left out.
    localparam logic [7:0] RISE_BITS = fei_pkg::LIVE_BITS & ~DONE_ONE;

    // The edge and live masks in the package must agree with the bit map used here.
    initial begin
        if (fei_pkg::LIVE_BITS[fei_pkg::BIT_STEP] || fei_pkg::LIVE_BITS[fei_pkg::BIT_ROW]) begin
            $error("fei_unit: step and row events must not have live bits");
        end
        if (fei_pkg::BOTH_EDGE != (BOOST_ONE | THP_ONE)) begin
            $error("fei_unit: only boost and thermal may report both edges");
        end
        if (!fei_pkg::LIVE_RESET[fei_pkg::BIT_DONE]) begin
            $error("fei_unit: scroll done must read idle after reset");
        end
    end

    // Analogue comparators are asynchronous to the core clock.
    fei_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rstn    (i_rstn),
        .i_async   ({i_boost_ok_cmp, i_row_short, i_rset_open_cmp,
                     i_rset_low_cmp, i_overtemp_cmp, i_overvolt_cmp}),
        .o_sync    (cmp_sync)
    );

    function automatic logic [7:0] edge_events(input logic [7:0] now, input logic [7:0] was);
        edge_events = (now & ~was) | ((now ^ was) & fei_pkg::BOTH_EDGE);
    endfunction : edge_events

    // One decoder for the latch clear, the mask write and the checks; the read-data case decodes the address itself.
    function automatic logic acc_hit(input fei_pkg::fei_acc_t acc, input logic rd,
                                     input logic [7:0] addr);
        acc_hit = (rd ? acc.rd : acc.wr) && (acc.addr == addr);
    endfunction : acc_hit

    logic [7:0] events;
    logic       rd_latch;

    always_comb begin
        st_nxt = st_r;
        rd_latch = acc_hit(i_acc, 1'b1, fei_pkg::ADDR_LATCH);

        // Comparators carry their own hysteresis, so status tracks their level.
        st_nxt.live = 8'h00;
        st_nxt.live[fei_pkg::BIT_BOOST] = cmp_sync[5];
        st_nxt.live[fei_pkg::BIT_THP]   = cmp_sync[1];
        st_nxt.live[fei_pkg::BIT_OVP]   = cmp_sync[0];
        st_nxt.live[fei_pkg::BIT_OPEN]  = st_r.open_flag;
        st_nxt.live[fei_pkg::BIT_SHORT] = st_r.low_flag;
        st_nxt.live[fei_pkg::BIT_DONE]  = ~i_scroll_busy;
        st_nxt.live_d = st_r.live;

        // Row short and scroll step are event inputs without a live bit.
        events = edge_events(st_r.live, st_r.live_d) & fei_pkg::LIVE_BITS;
        events[fei_pkg::BIT_ROW]  = cmp_sync[4] & ~st_r.live_d[fei_pkg::BIT_ROW];
        events[fei_pkg::BIT_STEP] = i_scroll_step;
        events[fei_pkg::BIT_DONE] = i_scroll_end;
        st_nxt.live_d[fei_pkg::BIT_ROW] = cmp_sync[4];

        // An event in the read cycle survives the clear.
        st_nxt.latch = (rd_latch ? 8'h00 : st_r.latch) | events;

        // The resistor is sampled once per driver enable write of one.
        st_nxt.check = i_driver_on_wr && i_driver_on_wdata;
        if (st_r.check) begin
            st_nxt.open_flag = cmp_sync[3];
            st_nxt.low_flag  = cmp_sync[2];
        end

        if (i_driver_on_wr) begin
            st_nxt.driver_on = i_driver_on_wdata;
        end
        if (i_boost_on_wr) begin
            st_nxt.boost_on = i_boost_on_wdata;
        end
        // Protection wins over a simultaneous host write.
        if (cmp_sync[1]) begin
            st_nxt.driver_on = 1'b0;
            st_nxt.boost_on  = 1'b0;
        end
        if (cmp_sync[0]) begin
            st_nxt.boost_on = 1'b0;
        end
        if (cmp_sync[4]) begin
            st_nxt.driver_on = 1'b0;
        end

        if (acc_hit(i_acc, 1'b0, fei_pkg::ADDR_MASK)) begin
            st_nxt.mask = i_acc.wdata;
        end

        st_nxt.rdata = 8'h00;
        if (i_acc.rd) begin
            case (i_acc.addr)
                fei_pkg::ADDR_MASK:  st_nxt.rdata = st_r.mask;
                fei_pkg::ADDR_LATCH: st_nxt.rdata = st_r.latch;
                fei_pkg::ADDR_LIVE:  st_nxt.rdata = st_r.live;
                default:             st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            st_r <= '{mask: fei_pkg::MASK_RESET, latch: fei_pkg::LATCH_RESET,
                      live: fei_pkg::LIVE_RESET, live_d: fei_pkg::LIVE_RESET,
                      rdata: 8'h00, driver_on: 1'b0, boost_on: 1'b0,
                      check: 1'b0, open_flag: 1'b0, low_flag: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata      = st_r.rdata;
    assign o_driver_on  = st_r.driver_on;
    assign o_boost_on   = st_r.boost_on;
    assign o_rset_check = st_r.check;
    assign o_irq        = |(st_r.latch & st_r.mask);

    // Each check reads registered state, so an effect shows one edge after its cause.
    mask_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(o_irq) |-> ($past(i_acc.wr) && $past(i_acc.addr) == fei_pkg::ADDR_MASK)
        || (($past(events) & st_r.mask) != 8'h00))
        else $error("irq rose without a cause");

    mask_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        acc_hit(i_acc, 1'b0, fei_pkg::ADDR_MASK) |=> st_r.mask == $past(i_acc.wdata))
        else $error("mask write lost");

    latch_sticky_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (st_r.latch != 8'h00 && !rd_latch) |=>
        ((st_r.latch & $past(st_r.latch)) == $past(st_r.latch)))
        else $error("latch bit lost without read");

    rise_event_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ((st_r.live & ~st_r.live_d & RISE_BITS) != 8'h00) |=>
        ((st_r.latch & $past(st_r.live & ~st_r.live_d & RISE_BITS))
        == $past(st_r.live & ~st_r.live_d & RISE_BITS))) else $error("rising source not latched");

    latch_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (rd_latch && events == 8'h00) |=> st_r.latch == 8'h00)
        else $error("latch not cleared by read");

    latch_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rd_latch |=> st_r.rdata == $past(st_r.latch))
        else $error("latch read returned wrong data");

    status_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        acc_hit(i_acc, 1'b1, fei_pkg::ADDR_LIVE) |=> st_r.rdata == $past(st_r.live))
        else $error("status read wrong");

    unmapped_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_acc.rd && i_acc.addr != fei_pkg::ADDR_MASK && i_acc.addr != fei_pkg::ADDR_LATCH
        && i_acc.addr != fei_pkg::ADDR_LIVE) |=> st_r.rdata == 8'h00)
        else $error("unmapped read not zero");

    live_boost_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.live[fei_pkg::BIT_BOOST] == $past(cmp_sync[5]))
        else $error("boost ready status stale");

    both_edge_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $fell(st_r.live[fei_pkg::BIT_THP]) |=> st_r.latch[fei_pkg::BIT_THP])
        else $error("thermal clear event missed");

    boost_edge_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $fell(st_r.live[fei_pkg::BIT_BOOST]) |=> st_r.latch[fei_pkg::BIT_BOOST])
        else $error("boost loss event missed");

    ovp_fall_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ($fell(st_r.live[fei_pkg::BIT_OVP]) && !st_r.latch[fei_pkg::BIT_OVP])
        |=> !st_r.latch[fei_pkg::BIT_OVP]) else $error("overvoltage clear raised event");

    live_thermal_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.live[fei_pkg::BIT_THP] == $past(cmp_sync[1]))
        else $error("thermal status stale");

    thermal_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        cmp_sync[1] |=> !o_driver_on && !o_boost_on)
        else $error("thermal did not disable");

    no_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (!o_driver_on && !o_boost_on && !i_driver_on_wr && !i_boost_on_wr)
        |=> !o_driver_on && !o_boost_on)
        else $error("enables came back without a write");

    live_ovp_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.live[fei_pkg::BIT_OVP] == $past(cmp_sync[0]))
        else $error("overvoltage status stale");

    ovp_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        cmp_sync[0] |=> !o_boost_on) else $error("overvoltage kept boost");

    check_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_driver_on_wr && i_driver_on_wdata) |=> o_rset_check)
        else $error("resistor check not started");

    open_sample_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.check |=> st_r.open_flag == $past(cmp_sync[3]))
        else $error("open resistor not sampled");

    low_sample_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.check |=> st_r.low_flag == $past(cmp_sync[2]))
        else $error("low resistor not sampled");

    low_keeps_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (st_r.low_flag && !cmp_sync[0] && !cmp_sync[1] && !cmp_sync[4]
        && !i_driver_on_wr && !i_boost_on_wr)
        |=> o_driver_on == $past(o_driver_on) && o_boost_on == $past(o_boost_on))
        else $error("low resistor changed enables");

    step_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_scroll_step |=> st_r.latch[fei_pkg::BIT_STEP] && !st_r.live[fei_pkg::BIT_STEP])
        else $error("scroll step not latched");

    live_done_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.live[fei_pkg::BIT_DONE] == !$past(i_scroll_busy))
        else $error("scroll done status stale");

    done_event_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_scroll_end |=> st_r.latch[fei_pkg::BIT_DONE])
        else $error("scroll done not latched");

    row_event_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(cmp_sync[4]) |=> st_r.latch[fei_pkg::BIT_ROW])
        else $error("row short not latched");

    row_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (cmp_sync[4] && !i_boost_on_wr && !cmp_sync[0] && !cmp_sync[1]) |=>
        !o_driver_on && o_boost_on == $past(o_boost_on))
        else $error("row short handling");

    irq_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (rd_latch && events == 8'h00) |=> !o_irq)
        else $error("irq stayed after latch read");

    irq_cov: cover property (@(posedge i_core_clk) disable iff (!i_rstn) $rose(o_irq));
    clear_cov: cover property (@(posedge i_core_clk) disable iff (!i_rstn) o_irq && rd_latch);
    therm_cov: cover property (@(posedge i_core_clk) disable iff (!i_rstn) $fell(cmp_sync[1]));
    step_cov: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(st_r.latch[fei_pkg::BIT_STEP]));
    open_cov: cover property (@(posedge i_core_clk) disable iff (!i_rstn) $rose(st_r.open_flag));

endmodule : fei_unit

`default_nettype wire

// file: test/fei_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host end of the register port: one access per call, one cycle wide.
module fei_host (
    input  wire logic             i_core_clk,
    input  wire logic [7:0]       i_rdata,
    output var fei_pkg::fei_acc_t o_acc
);
    initial o_acc = '0;

    // Released address and data are inverted so that a stale value never matches.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge i_core_clk);
        o_acc = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge i_core_clk);
        o_acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        q = i_rdata;
    endtask : acc
endmodule : fei_host

`default_nettype wire

// file: test/fault_event_interrupt_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

module fault_event_interrupt_unit_test;
    localparam logic [7:0] A_MSK = fei_pkg::ADDR_MASK;
    localparam logic [7:0] A_LAT = fei_pkg::ADDR_LATCH;
    localparam logic [7:0] A_LIV = fei_pkg::ADDR_LIVE;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [7:0]        src = 8'h00;
    logic              dwr = 1'b0;
    logic              bwr = 1'b0;
    logic              dwd = 1'b1;
    logic              bwd = 1'b1;
    logic              busy = 1'b0;
    logic              chkp;
    logic [7:0]        q;
    logic [7:0]        rdata;
    logic              drv;
    logic              bst;
    logic              irq;
    int                fails = 0;
    int                tests_run = 0;
    fei_pkg::fei_acc_t acc;
    // Per source: live value while active, driver-on, boost-on, event on both edges.
    logic [10:0]       tab [8] = '{11'h10C, 11'h111, 11'h126, 11'h146,
                                   11'h106, 11'h106, 11'h102, 11'h507};

    initial forever #25 clk = ~clk;

    fei_unit dut (.i_core_clk(clk), .i_rstn(rstn), .i_acc(acc),
        .i_boost_ok_cmp(src[7]), .i_row_short(src[6]), .i_rset_open_cmp(src[2]),
        .i_rset_low_cmp(src[3]), .i_overtemp_cmp(src[1]), .i_overvolt_cmp(src[0]),
        .i_scroll_step(src[4]), .i_scroll_end(src[5]), .i_scroll_busy(busy),
        .i_driver_on_wr(dwr), .i_driver_on_wdata(dwd), .i_boost_on_wr(bwr),
        .i_boost_on_wdata(bwd), .o_rdata(rdata), .o_driver_on(drv),
        .o_boost_on(bst), .o_rset_check(chkp), .o_irq(irq));

    fei_host h (.i_core_clk(clk), .i_rdata(rdata), .o_acc(acc));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        h.acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask : rd

    task automatic en(input logic b);
        @(negedge clk);
        dwr = 1'b1;
        bwr = b;
        @(negedge clk);
        dwr = 1'b0;
        bwr = 1'b0;
    endtask : en

    task automatic rst;
        rstn = 1'b0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        chk({drv, bst, irq}, 8'h00);
        rd(A_MSK, 8'h00);
        rd(A_LAT, 8'h00);
        rd(A_LIV, 8'h20);
    endtask : rst

    task automatic summarize;
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        #2000000;
        fails++;
        summarize();
    end

    initial begin
        rst();
        for (int i = 0; i < 8; i++) begin
            h.acc(1'b1, A_MSK, 8'h01 << i, q);
            en(1'b1);
            src[i] = 1'b1;
            if (i == 4 || i == 5) begin
                @(negedge clk);
                src[i] = 1'b0;
            end
            repeat (6) @(negedge clk);
            // The resistor is only judged when driver-on is written again.
            if (i == 2 || i == 3) en(1'b0);
            repeat (8) @(negedge clk);
            chk({7'h00, irq}, 8'h01);
            chk({drv, bst}, tab[i][2:1]);
            rd(A_LIV, tab[i][10:3]);
            rd(A_LAT, 8'h01 << i);
            rd(A_LAT, 8'h00);
            chk({7'h00, irq}, 8'h00);
            rd(A_LIV, tab[i][10:3]);
            src[i] = 1'b0;
            repeat (8) @(negedge clk);
            rd(A_LAT, tab[i][0] ? 8'h01 << i : 8'h00);
            chk({drv, bst}, tab[i][2:1]);
        end
        h.acc(1'b1, A_MSK, 8'hA5, q);
        h.acc(1'b1, A_LAT, 8'hFF, q);
        h.acc(1'b1, A_LIV, 8'hFF, q);
        rd(A_MSK, 8'hA5);
        rd(A_LAT, 8'h00);
        rd(A_LIV, 8'h20);
        rd(8'h99, 8'h00);
        // A masked source still latches but keeps the request quiet.
        src[4] = 1'b1;
        @(negedge clk);
        src[4] = 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        h.acc(1'b1, A_MSK, 8'h10, q);
        chk({7'h00, irq}, 8'h01);
        rd(A_LAT, 8'h10);
        h.acc(1'b1, A_MSK, 8'h10, q);
        // A driver-on write of one starts a single-cycle resistor check.
        @(negedge clk);
        dwr = 1'b1;
        @(negedge clk);
        dwr = 1'b0;
        chk({7'h00, chkp}, 8'h01);
        @(negedge clk);
        chk({7'h00, chkp}, 8'h00);
        dwd = 1'b0;
        en(1'b0);
        chk({drv, bst}, 8'h01);
        chk({7'h00, chkp}, 8'h00);
        dwd = 1'b1;
        bwd = 1'b0;
        en(1'b1);
        chk({drv, bst}, 8'h02);
        bwd = 1'b1;
        busy = 1'b1;
        repeat (2) @(negedge clk);
        rd(A_LIV, 8'h00);
        busy = 1'b0;
        rst();
        summarize();
    end
endmodule : fault_event_interrupt_unit_test

`default_nettype wire
